// >>> rtl/bsbs_pkg.sv
// Constants, encodings and carrier types for the branch/skip/bit/shift unit
package bsbs_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int BSBS_PC_W   = 16;
    localparam int BSBS_DATA_W = 8;
    localparam int BSBS_ADDR_W = 5;

    // ------------------------------------------------------------
    // Status flag positions
    // ------------------------------------------------------------
    localparam int BSBS_FLAG_C = 0;
    localparam int BSBS_FLAG_Z = 1;
    localparam int BSBS_FLAG_N = 2;
    localparam int BSBS_FLAG_V = 3;
    localparam int BSBS_FLAG_S = 4;

    // ------------------------------------------------------------
    // Opcode masks and match values
    // ------------------------------------------------------------
    localparam logic [15:0] BSBS_BR_MASK   = 16'hFC00;
    localparam logic [15:0] BSBS_BR_SET    = 16'hF000;
    localparam logic [15:0] BSBS_BR_CLR    = 16'hF400;
    localparam logic [15:0] BSBS_IO_MASK   = 16'hFF00;
    localparam logic [15:0] BSBS_SKIP_SET  = 16'h9B00;
    localparam logic [15:0] BSBS_IO_SET    = 16'h9A00;
    localparam logic [15:0] BSBS_IO_CLR    = 16'h9800;
    localparam logic [15:0] BSBS_SH_MASK   = 16'hFC00;
    localparam logic [15:0] BSBS_SHL       = 16'h0C00;
    localparam logic [15:0] BSBS_ROL       = 16'h1C00;
    localparam logic [15:0] BSBS_SHR_MASK  = 16'hFE0F;
    localparam logic [15:0] BSBS_SHR       = 16'h9406;

    // ------------------------------------------------------------
    // Extra cycles and program counter steps
    // ------------------------------------------------------------
    localparam logic [1:0] BSBS_XTRA_BRANCH = 2'h1;
    localparam logic [1:0] BSBS_XTRA_SHORT  = 2'h1;
    localparam logic [1:0] BSBS_XTRA_LONG   = 2'h2;
    localparam logic [1:0] BSBS_XTRA_IOBIT  = 2'h1;
    localparam logic [BSBS_PC_W-1:0] BSBS_STEP_SHORT = 16'h0002;
    localparam logic [BSBS_PC_W-1:0] BSBS_STEP_LONG  = 16'h0003;

    // Sequencer states
    typedef enum logic [0:0] {
        BSBS_EXEC = 1'b0,
        BSBS_HOLD = 1'b1
    } bsbs_state_t;

    // Instruction from fetch
    typedef struct packed {
        logic                 valid;
        logic [15:0]          word;
        logic [BSBS_PC_W-1:0] pc;
        logic                 next_long;
    } bsbs_fetch_t;

    // Program counter load
    typedef struct packed {
        logic                 load;
        logic [BSBS_PC_W-1:0] target;
    } bsbs_pc_t;

    // Status register write
    typedef struct packed {
        logic                   we;
        logic [BSBS_DATA_W-1:0] value;
    } bsbs_status_flags_register_t;

    // Register or I/O write
    typedef struct packed {
        logic                   we;
        logic [BSBS_ADDR_W-1:0] addr;
        logic [BSBS_DATA_W-1:0] data;
    } bsbs_wr_t;
endpackage

// >>> rtl/bsbs_exec.sv
// Execution of flag branches, I/O bit skip, I/O bit set/clear and shifts
// ------------------------------------------------------------
// What this block does
// - Skip next instruction when I/O bit is one; flags untouched.
// - Flag-set branch tests indexed status bit, jumps to pc+k+1.
// - Flag-clear branch jumps to pc+k+1 when indexed bit is zero.
// - Equal uses Z one, not-equal uses Z zero; flags kept.
// - Carry-clear/same-or-higher on C zero; carry-set/lower on C one.
// - Negative branch on N one, positive branch on N zero.
// - Signed ge when N xor V is zero, lt when one.
// - Half-carry branches on H one or zero.
// - T-bit branches on T one or zero, flags kept.
// - Overflow branches on V one or zero.
// - Interrupt branches on I one or zero.
// - Set I/O bit writes one, others kept, two cycles.
// - Clear I/O bit writes zero, others kept, no flags.
// - Left shift inserts zero at bit 0, updates Z C N V.
// - Right shift inserts zero at bit 7, updates Z C N V.
// - Rotate left through carry, old bit 7 into carry.
// ------------------------------------------------------------
`timescale 1ns/10ps
module bsbs_exec (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Instruction fetch
    input  wire bsbs_pkg::bsbs_fetch_t fetch_i,
    output logic                      ready_o,
    output bsbs_pkg::bsbs_pc_t        pc_o,
    // Status register
    input  wire logic [7:0]           status_flags_register_i,
    output bsbs_pkg::bsbs_status_flags_register_t      status_flags_register_o,
    // Working registers
    output logic [4:0]                rf_addr_o,
    input  wire logic [7:0]           rf_rdata_i,
    output bsbs_pkg::bsbs_wr_t        rf_o,
    // I/O register space
    output logic [4:0]                io_addr_o,
    input  wire logic [7:0]           io_rdata_i,
    output bsbs_pkg::bsbs_wr_t        io_o
);
    import bsbs_pkg::*;

    bsbs_state_t            state_reg;
    logic [1:0]             cnt_reg;
    logic                   acc;
    logic [15:0]            w;
    logic                   is_brs;
    logic                   is_brc;
    logic                   is_skip;
    logic                   is_sbit;
    logic                   is_cbit;
    logic                   is_shl;
    logic                   is_rol;
    logic                   is_shr;
    logic                   flag_sel;
    logic                   taken;
    logic                   io_bit;
    logic [7:0]             bit_mask;
    logic [BSBS_PC_W-1:0]   offset;
    logic [BSBS_PC_W-1:0]   br_target;
    logic [7:0]             sh_res;
    logic                   sh_c;
    logic [7:0]             sh_flags;

    // Clock and reset shared by every check at the foot of this module
    default clocking chk_cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign w        = fetch_i.word;
    assign ready_o  = (state_reg == BSBS_EXEC);
    assign acc      = fetch_i.valid && ready_o;
    assign is_brs   = (w & BSBS_BR_MASK) == BSBS_BR_SET;
    assign is_brc   = (w & BSBS_BR_MASK) == BSBS_BR_CLR;
    assign is_skip  = (w & BSBS_IO_MASK) == BSBS_SKIP_SET;
    assign is_sbit  = (w & BSBS_IO_MASK) == BSBS_IO_SET;
    assign is_cbit  = (w & BSBS_IO_MASK) == BSBS_IO_CLR;
    // Shift aliases use the same register on both operands
    assign is_shl   = ((w & BSBS_SH_MASK) == BSBS_SHL)
                      && ({w[9], w[3:0]} == w[8:4]);
    assign is_rol   = ((w & BSBS_SH_MASK) == BSBS_ROL)
                      && ({w[9], w[3:0]} == w[8:4]);
    assign is_shr   = (w & BSBS_SHR_MASK) == BSBS_SHR;

    // Operand addresses straight from the word
    assign rf_addr_o = w[8:4];
    assign io_addr_o = w[7:3];
    assign io_bit    = io_rdata_i[w[2:0]];
    assign bit_mask  = 8'h01 << w[2:0];

    // ------------------------------------------------------------
    // Branch condition and target
    // ------------------------------------------------------------
    // Signed test uses N xor V, other indices read the flag itself
    always_comb begin
        if (w[2:0] == 3'(BSBS_FLAG_S)) begin
            flag_sel = status_flags_register_i[BSBS_FLAG_N] ^ status_flags_register_i[BSBS_FLAG_V];
        end else begin
            flag_sel = status_flags_register_i[w[2:0]];
        end
    end

    // Set form wants one, clear form wants zero
    assign taken = (is_brs && flag_sel)
                   || (is_brc && !flag_sel);
    // Same selection covers V and I indices too
    assign offset    = {{(BSBS_PC_W-7){w[9]}}, w[9:3]};
    assign br_target = fetch_i.pc + offset + 16'h0001;

    // ------------------------------------------------------------
    // Shift datapath
    // ------------------------------------------------------------
    always_comb begin
        sh_res = {rf_rdata_i[6:0], 1'b0};
        sh_c   = rf_rdata_i[7];
        if (is_rol) begin
            sh_res = {rf_rdata_i[6:0], status_flags_register_i[BSBS_FLAG_C]};
        end else if (is_shr) begin
            sh_res = {1'b0, rf_rdata_i[7:1]};
            sh_c   = rf_rdata_i[0];
        end
        sh_flags                = status_flags_register_i;
        sh_flags[BSBS_FLAG_C]   = sh_c;
        sh_flags[BSBS_FLAG_Z]   = (sh_res == 8'h00);
        sh_flags[BSBS_FLAG_N]   = sh_res[7];
        sh_flags[BSBS_FLAG_V]   = sh_res[7] ^ sh_c;
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Hold off fetch for the extra cycles of a multi-cycle instruction
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= BSBS_EXEC;
            cnt_reg   <= 2'h0;
        end else begin
            case (state_reg)
                BSBS_EXEC: begin
                    if (acc && taken) begin
                        state_reg <= BSBS_HOLD;
                        cnt_reg   <= BSBS_XTRA_BRANCH;
                    end else if (acc && is_skip && io_bit) begin
                        state_reg <= BSBS_HOLD;
                        cnt_reg   <= fetch_i.next_long ? BSBS_XTRA_LONG
                                                       : BSBS_XTRA_SHORT;
                    end else if (acc && (is_sbit || is_cbit)) begin
                        state_reg <= BSBS_HOLD;
                        cnt_reg   <= BSBS_XTRA_IOBIT;
                    end
                end
                BSBS_HOLD: begin
                    if (cnt_reg == 2'h1) begin
                        state_reg <= BSBS_EXEC;
                    end
                    cnt_reg <= cnt_reg - 2'h1;
                end
                default: begin
                    state_reg <= BSBS_EXEC;
                    cnt_reg   <= 2'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Program counter load
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            pc_o <= '0;
        end else begin
            pc_o.load <= 1'b0;
            if (acc && taken) begin
                pc_o.load   <= 1'b1;
                pc_o.target <= br_target;
            end else if (acc && is_skip && io_bit) begin
                pc_o.load   <= 1'b1;
                pc_o.target <= fetch_i.pc + (fetch_i.next_long
                               ? BSBS_STEP_LONG : BSBS_STEP_SHORT);
            end
        end
    end

    // ------------------------------------------------------------
    // Status and register write back
    // ------------------------------------------------------------
    // Only the shifts touch flags; branches, skips and bit ops do not
    always_ff @(posedge clk) begin
        if (rst) begin
            status_flags_register_o <= '0;
            rf_o   <= '0;
        end else begin
            status_flags_register_o.we <= 1'b0;
            rf_o.we   <= 1'b0;
            if (acc && (is_shl || is_rol || is_shr)) begin
                status_flags_register_o.we    <= 1'b1;
                status_flags_register_o.value <= sh_flags;
                rf_o.we      <= 1'b1;
                rf_o.addr    <= w[8:4];
                rf_o.data    <= sh_res;
            end
        end
    end

    // ------------------------------------------------------------
    // I/O bit read-modify-write
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            io_o <= '0;
        end else begin
            io_o.we <= 1'b0;
            if (acc && is_sbit) begin
                io_o.we   <= 1'b1;
                io_o.addr <= w[7:3];
                io_o.data <= io_rdata_i | bit_mask;
            end else if (acc && is_cbit) begin
                io_o.we   <= 1'b1;
                io_o.addr <= w[7:3];
                io_o.data <= io_rdata_i & ~bit_mask;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_SKIP_SHORT: assert property (
        acc && is_skip && io_bit && !fetch_i.next_long |=>
        pc_o.load && pc_o.target == $past(fetch_i.pc) + 16'h0002
        && !ready_o ##1 ready_o)
        else $error("short skip wrong");
    AST_SKIP_LONG: assert property (
        acc && is_skip && io_bit && fetch_i.next_long |=>
        pc_o.target == $past(fetch_i.pc) + 16'h0003
        ##0 !ready_o [*2] ##1 ready_o)
        else $error("long skip wrong");
    AST_BR_TAKEN: assert property (
        acc && is_brs && status_flags_register_i[w[2:0]] && w[2:0] != 3'h4 |=>
        pc_o.load && !ready_o && pc_o.target == $past(fetch_i.pc)
        + {{9{$past(w[9])}}, $past(w[9:3])} + 16'h0001)
        else $error("set branch not taken");
    AST_BR_CLR_UNTAKEN: assert property (
        acc && is_brc && status_flags_register_i[w[2:0]] && w[2:0] != 3'h4 |=>
        !pc_o.load && ready_o)
        else $error("clear branch taken on one");
    AST_BR_SIGNED: assert property (
        acc && is_brc && w[2:0] == 3'h4 |=>
        pc_o.load == !($past(status_flags_register_i[2]) ^ $past(status_flags_register_i[3])))
        else $error("signed ge condition wrong");
    AST_BR_NO_FLAGS: assert property (
        acc && (is_brs || is_brc || is_skip) |=> !status_flags_register_o.we && !rf_o.we)
        else $error("branch altered flags");
    AST_BR_TWO_CYC: assert property (
        acc && taken |=> !ready_o ##1 ready_o && !pc_o.load)
        else $error("taken branch cycle count");
    AST_SET_BIT: assert property (
        acc && is_sbit |=> io_o.we && io_o.data == ($past(io_rdata_i)
        | (8'h01 << $past(w[2:0]))) && !ready_o ##1 ready_o && !io_o.we)
        else $error("set bit wrong");
    AST_CLR_BIT: assert property (
        acc && is_cbit |=> io_o.we && !status_flags_register_o.we && io_o.data ==
        ($past(io_rdata_i) & ~(8'h01 << $past(w[2:0]))))
        else $error("clear bit wrong");
    AST_SHL: assert property (
        acc && is_shl |=> rf_o.we && rf_o.data == {$past(rf_rdata_i[6:0]),
        1'b0} && status_flags_register_o.value[0] == $past(rf_rdata_i[7]) && ready_o)
        else $error("left shift wrong");
    AST_SHR: assert property (
        acc && is_shr |=> rf_o.data == {1'b0, $past(rf_rdata_i[7:1])}
        && status_flags_register_o.value[0] == $past(rf_rdata_i[0]) && !status_flags_register_o.value[2])
        else $error("right shift wrong");
    AST_ROL: assert property (
        acc && is_rol |=> rf_o.data[0] == $past(status_flags_register_i[0])
        && status_flags_register_o.value[0] == $past(rf_rdata_i[7])
        && status_flags_register_o.value[1] == (rf_o.data == 8'h00))
        else $error("rotate wrong");
    // Opposite polarities, the quiet skip and the held cycles
    AST_BR_CLR_TAKEN: assert property (
        acc && is_brc && !status_flags_register_i[w[2:0]] && w[2:0] != 3'h4 |=>
        pc_o.load && !ready_o && pc_o.target == $past(fetch_i.pc)
        + {{9{$past(w[9])}}, $past(w[9:3])} + 16'h0001)
        else $error("clear branch not taken on zero");
    AST_BR_SET_UNTAKEN: assert property (
        acc && is_brs && !status_flags_register_i[w[2:0]] && w[2:0] != 3'h4 |=>
        !pc_o.load && ready_o)
        else $error("set branch taken on zero");
    AST_SKIP_NONE: assert property (
        acc && is_skip && !io_rdata_i[w[2:0]] |=> !pc_o.load && ready_o)
        else $error("skip taken on clear bit");
    AST_BIT_NO_FLAGS: assert property (
        acc && (is_sbit || is_cbit) |=> !status_flags_register_o.we && !rf_o.we
        && !pc_o.load)
        else $error("bit write touched flags or registers");
    AST_HOLD_QUIET: assert property (
        !ready_o |=> !pc_o.load && !io_o.we && !rf_o.we && !status_flags_register_o.we)
        else $error("write issued while held");
endmodule // bsbs_exec

// >>> verification/bsbs_far_model.sv
// Far-side model: status flags, working registers and I/O space
`timescale 1ns/10ps
module bsbs_far_model (
    // Clock
    input  wire logic                 clk,
    // Unit side
    input  wire logic [4:0]           rf_addr_i,
    input  wire logic [4:0]           io_addr_i,
    input  wire bsbs_pkg::bsbs_status_flags_register_t status_flags_register_i,
    input  wire bsbs_pkg::bsbs_wr_t   rf_i,
    input  wire bsbs_pkg::bsbs_wr_t   io_i,
    output logic [7:0]                status_flags_register_o,
    output logic [7:0]                rf_rdata_o,
    output logic [7:0]                io_rdata_o
);
    import bsbs_pkg::*;
    logic [7:0] rf_mem [32];
    logic [7:0] io_mem [32];
    logic [7:0] flags_q;
    // Same-cycle reads, as the register file and I/O space give them
    assign rf_rdata_o = rf_mem[rf_addr_i];
    assign io_rdata_o = io_mem[io_addr_i];
    assign status_flags_register_o     = flags_q;
    // Writes from the unit land on the rising edge
    always @(posedge clk) begin
        if (status_flags_register_i.we) flags_q <= status_flags_register_i.value;
        if (rf_i.we) rf_mem[rf_i.addr] <= rf_i.data;
        if (io_i.we) io_mem[io_i.addr] <= io_i.data;
    end
endmodule // bsbs_far_model

// >>> verification/bsbs_exec_tb.sv
// Self-checking bench for the branch, skip, bit and shift unit
`timescale 1ns/10ps
module branch_skip_bit_shift_exec_tb;
    import bsbs_pkg::*;
    logic        clk;
    logic        rst;
    bsbs_fetch_t fetch;
    logic        ready;
    bsbs_pc_t    pc_out;
    logic [7:0]  status_flags_register_in;
    bsbs_status_flags_register_t  status_flags_register_out;
    logic [4:0]  rf_addr;
    logic [7:0]  rf_rd;
    bsbs_wr_t    rf_wr;
    logic [4:0]  io_addr;
    logic [7:0]  io_rd;
    bsbs_wr_t    io_wr;
    int          errors;
    int          total_checks;
    int          cycles;
    int          seed;
    logic [31:0] r;

    bsbs_exec dut_u (.clk(clk), .rst(rst), .fetch_i(fetch), .ready_o(ready),
        .pc_o(pc_out), .status_flags_register_i(status_flags_register_in), .status_flags_register_o(status_flags_register_out),
        .rf_addr_o(rf_addr), .rf_rdata_i(rf_rd), .rf_o(rf_wr),
        .io_addr_o(io_addr), .io_rdata_i(io_rd), .io_o(io_wr));
    bsbs_far_model model_u (.clk(clk), .rf_addr_i(rf_addr),
        .io_addr_i(io_addr), .status_flags_register_i(status_flags_register_out), .rf_i(rf_wr), .io_i(io_wr),
        .status_flags_register_o(status_flags_register_in), .rf_rdata_o(rf_rd), .io_rdata_o(io_rd));

    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            errors++;
            results;
        end
    end

    // Verdict and end of run
    task automatic results;
        if (errors == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Comparisons, one per result width
    task automatic chk_bit(input string nm, input logic e, input logic s);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("BAD %s exp %b got %b", nm, e, s);
        end
    endtask
    task automatic chk_byte(input string nm, input logic [7:0] e,
                            input logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic chk_word(input string nm, input logic [15:0] e,
                            input logic [15:0] s);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    // Offer one word at a falling edge, drop it one cycle later
    task automatic issue(input logic [15:0] w, input logic [15:0] pc,
                         input logic nl);
        fetch = {1'b1, w, pc, nl};
        @(negedge clk);
        fetch.valid = 1'b0;
    endtask
    // Expected branch outcome from the flag byte
    function automatic logic taken(input logic [2:0] s, input logic clr,
                                   input logic [7:0] f);
        return ((s == 3'h4) ? (f[2] ^ f[3]) : f[s]) ^ clr;
    endfunction

    // Generic flag branch, any index and polarity
    task automatic do_branch(input logic [2:0] s, input logic clr,
                             input logic [6:0] k, input logic [7:0] f,
                             input logic [15:0] pc);
        logic tk;
        tk = taken(s, clr, f);
        model_u.flags_q = f;
        issue((clr ? BSBS_BR_CLR : BSBS_BR_SET) | {6'h00, k, s}, pc, 1'b0);
        chk_bit("br_load", tk, pc_out.load);
        if (tk) chk_word("br_target", pc + 16'h0001 + {{9{k[6]}}, k},
                         pc_out.target);
        chk_bit("br_flag_we", 1'b0, status_flags_register_out.we);
        chk_bit("br_ready", !tk, ready);
        @(negedge clk);
        chk_bit("br_ready2", 1'b1, ready);
    endtask
    // Skip on I/O bit set, short or long
    task automatic do_skip(input logic [4:0] a, input logic [2:0] b,
                           input logic [7:0] v, input logic nl);
        logic tk;
        tk = v[b];
        model_u.io_mem[a] = v;
        issue(BSBS_SKIP_SET | {8'h00, a, b}, 16'h0100, nl);
        chk_bit("sk_load", tk, pc_out.load);
        if (tk) chk_word("sk_target", nl ? 16'h0103 : 16'h0102,
                         pc_out.target);
        chk_bit("sk_flag_we", 1'b0, status_flags_register_out.we);
        chk_bit("sk_ready", !tk, ready);
        @(negedge clk);
        chk_bit("sk_ready2", !(tk && nl), ready);
        if (tk && nl) @(negedge clk);
        chk_bit("sk_ready3", 1'b1, ready);
    endtask
    // Set or clear one I/O bit
    task automatic do_bit(input logic clr, input logic [4:0] a,
                          input logic [2:0] b, input logic [7:0] v);
        logic [7:0] e;
        e = clr ? (v & ~(8'h01 << b)) : (v | (8'h01 << b));
        model_u.io_mem[a] = v;
        issue((clr ? BSBS_IO_CLR : BSBS_IO_SET) | {8'h00, a, b}, 16'h0, 1'b0);
        chk_bit("io_we", 1'b1, io_wr.we);
        chk_word("io_addr", {11'h000, a}, {11'h000, io_wr.addr});
        chk_byte("io_data", e, io_wr.data);
        chk_bit("io_flag_we", 1'b0, status_flags_register_out.we);
        chk_bit("io_ready", 1'b0, ready);
        @(negedge clk);
        chk_bit("io_we2", 1'b0, io_wr.we);
        chk_byte("io_mem", e, model_u.io_mem[a]);
    endtask
    // Shift or rotate of one working register
    task automatic do_shift(input logic [1:0] op, input logic [4:0] d,
                            input logic [7:0] v, input logic [7:0] f);
        logic [7:0]  q;
        logic        c;
        logic [15:0] w;
        model_u.rf_mem[d] = v;
        model_u.flags_q = f;
        c = (op == 2'h1) ? v[0] : v[7];
        case (op)
            2'h0:    q = {v[6:0], 1'b0};
            2'h1:    q = {1'b0, v[7:1]};
            default: q = {v[6:0], f[0]};
        endcase
        if (op == 2'h1) w = BSBS_SHR | {7'h00, d, 4'h0};
        else w = ((op == 2'h0) ? BSBS_SHL : BSBS_ROL)
                 | {6'h00, d[4], d, d[3:0]};
        issue(w, 16'h0, 1'b0);
        chk_bit("sh_we", 1'b1, rf_wr.we);
        chk_byte("sh_addr", {3'h0, d}, {3'h0, rf_wr.addr});
        chk_byte("sh_data", q, rf_wr.data);
        chk_byte("sh_flags", {f[7:4], q[7] ^ c, q[7], q == 8'h00, c},
                 status_flags_register_out.value);
        chk_bit("sh_ready", 1'b1, ready);
    endtask

    // Main sequence
    initial begin
        seed = 53945;
        errors = 0;
        total_checks = 0;
        cycles = 0;
        rst = 1'b1;
        fetch = '0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 32; i++) begin
            do_branch(i[2:0], i[3], 7'h05, (i[2:0] == 3'h4)
                ? (i[4] ? 8'h04 : 8'h0C) : {8{i[4]}},
                16'h0200);
        end
        do_branch(3'h1, 1'b0, 7'h40, 8'h02, 16'h0010);
        do_branch(3'h1, 1'b0, 7'h3F, 8'h02, 16'hFFF0);
        issue(16'h0000, 16'h0, 1'b0);
        chk_bit("nop_load", 1'b0, pc_out.load);
        do_skip(5'h1F, 3'h7, 8'h80, 1'b1);
        do_skip(5'h00, 3'h7, 8'h7F, 1'b1);
        do_shift(2'h0, 5'h1F, 8'h80, 8'h00);
        do_shift(2'h1, 5'h10, 8'h01, 8'hF0);
        do_shift(2'h2, 5'h0F, 8'h00, 8'h01);
        // Reset in the middle of a long skip frees the unit at once
        model_u.io_mem[5'h03] = 8'h01;
        issue(BSBS_SKIP_SET | 16'h0018, 16'h0100, 1'b1);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        chk_bit("rst_ready", 1'b1, ready);
        chk_bit("rst_load", 1'b0, pc_out.load);
        for (int i = 0; i < 200; i++) begin
            r = $random(seed);
            case (r[2:0])
                3'h0, 3'h1, 3'h2: do_branch(r[5:3], r[6], r[13:7], r[21:14],
                    r[31:16]);
                3'h3: do_skip(r[7:3], r[10:8], r[18:11], r[19]);
                3'h4, 3'h5: do_bit(r[0], r[7:3], r[10:8],
                    r[18:11]);
                default: do_shift(r[4:3], r[9:5], r[17:10],
                    r[25:18]);
            endcase
        end
        results;
    end
endmodule // branch_skip_bit_shift_exec_tb
